// File: pkg/wdtps_pkg.sv
// watchdog timer with postscaler: shared constants, register map and types
// assumes a 20 MHz core clock and a byte-addressed 32-bit register bus
package wdtps_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned WDT_TICK_NS     = 32000;
  localparam int unsigned WDT_TICK_CYCLES = WDT_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WDT_BASE_TICKS  = 576;

  // counter widths
  localparam int unsigned TICK_W = 16;
  localparam int unsigned BASE_W = 16;
  localparam int unsigned POST_W = 7;
  localparam int unsigned ADDR_W = 5;

  // 1:128 at select 000, halved per step
  localparam logic [6:0] POST_LIMIT_MAX = 7'h7F;

  // register byte offsets
  localparam logic [4:0] REG_SOFT_CTRL = 5'h00;
  localparam logic [4:0] REG_FUSE      = 5'h04;
  localparam logic [4:0] REG_CAUSE     = 5'h08;
  localparam logic [4:0] REG_IRQ_STAT  = 5'h0C;
  localparam logic [4:0] REG_IRQ_CLR   = 5'h10;
  localparam logic [4:0] REG_IRQ_EN    = 5'h14;
  localparam logic [4:0] REG_STATUS    = 5'h18;
  localparam logic [4:0] REG_COUNT     = 5'h1C;

  // field positions
  localparam int unsigned SOFT_EN_BIT   = 0;
  localparam int unsigned CAUSE_TO_BIT  = 3;
  localparam int unsigned CAUSE_PD_BIT  = 2;
  localparam int unsigned EV_RST_BIT    = 0;
  localparam int unsigned EV_WAKE_BIT   = 1;
  localparam int unsigned ST_RUN_BIT    = 0;
  localparam int unsigned ST_SLEEP_BIT  = 1;
  localparam int unsigned CNT_POST_LSB  = 16;

  // reset values
  localparam logic       SOFT_EN_RESET = 1'h0;
  localparam logic       CAUSE_TO_RESET = 1'h1;
  localparam logic       CAUSE_PD_RESET = 1'h1;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] unused;
    logic [2:0] postscale_select;
    logic       fuse_watchdog_enable;
  } wdtps_fuse_t;

  typedef struct packed {
    logic wake;
    logic reset;
  } wdtps_events_t;

  typedef enum logic {WDTPS_AWAKE, WDTPS_ASLEEP} wdtps_pwr_t;

endpackage

// File: hdl/wdtps_top.sv
// watchdog timer with fuse-selected postscaler, sleep wake-up and avalon registers
// assumes cpu instruction strobes and fuse byte are synchronous to CORE_CLK_IN
// assumes the fuse byte is stable while SYS_RST_IN is high
// assumes the system acts on WDT_RESET_OUT; the block never resets itself
//
// Overview of operation
// - postscale code 000 is 1:128, 111 is 1:1
// - fuse enable runs watchdog, else software bit
// - own oscillator tick keeps counting during sleep
// - time-out while awake requests full device reset
// - time-out while asleep wakes, no reset
// - every time-out clears the time-out flag
// - software cannot stop a fuse-enabled watchdog
// - clear or sleep instruction zeroes count, postscaler
// - clear zeroes count, postscale assignment kept
// - software enable readable, writable, zero after reset
// - postscale ratio only from programmed fuse
// - upper seven control bits read zero
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/100ps

module wdtps_top
  import wdtps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = WDT_TICK_CYCLES,
  parameter int unsigned BASE_TICKS  = WDT_BASE_TICKS
) (
  // clock and reset
  input  wire logic              CORE_CLK_IN,
  input  wire logic              SYS_RST_IN,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  input  wire logic [3:0]        AVS_BYTEENABLE_IN,
  output logic [31:0]            AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  output logic [1:0]             AVS_RESPONSE_OUT,
  // programmed fuse byte
  input  wire wdtps_fuse_t       FUSE_CFG_IN,
  // cpu instruction strobes and other wake sources
  input  wire logic              WATCHDOG_CLEAR_INSTRUCTION_IN,
  input  wire logic              SLEEP_INSTRUCTION_IN,
  input  wire logic              WAKE_EVENT_IN,
  // system outputs
  output logic                   WDT_RESET_OUT,
  output logic                   WDT_WAKE_OUT,
  output logic                   ASLEEP_OUT,
  output logic                   IRQ_OUT
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_TICKS - 1);

  // fuse copy, loaded while reset is asserted, frozen once reset is released
  wdtps_fuse_t         fuse_r;
  // software control
  logic                soft_en_r;
  // counters
  logic [TICK_W-1:0]   tick_div_r;
  logic [BASE_W-1:0]   base_cnt_r;
  logic [POST_W-1:0]   post_cnt_r;
  // power state and cause flags
  wdtps_pwr_t          pwr_r;
  logic                to_flag_r;
  logic                pd_flag_r;
  // interrupt registers
  logic [1:0]          irq_stat_r;
  logic [1:0]          irq_en_r;
  // outputs
  wdtps_events_t       ev_out_r;
  // bus
  logic                ack_r;
  logic [31:0]         rdata_r;
  logic [1:0]          resp_r;

  logic                run;
  logic                rc_tick;
  logic                base_end;
  logic [POST_W-1:0]   post_limit;
  logic                sleep_take;
  logic                restart;
  logic                timeout;
  wdtps_events_t       ev;
  logic                bus_req;
  logic                bus_first;
  logic                wr_take;
  logic                addr_hit;
  logic [31:0]         rd_mux;
  logic [1:0]          irq_clr;
  logic [1:0]          irq_set;
  logic                sel_soft;
  logic                sel_irq_en;
  logic                sel_irq_clr;

  // fuse is programmed once; sampling it only in reset keeps the ratio fixed at runtime
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      fuse_r <= FUSE_CFG_IN;
    end
  end

  // enable: fuse wins, software only matters with fuse bit clear
  assign run = fuse_r.fuse_watchdog_enable | soft_en_r;

  // ratio limit: 127 >> select gives 128,64,..,1 periods
  assign post_limit = POST_LIMIT_MAX >> fuse_r.postscale_select;

  // sleep instruction is only taken while awake
  assign sleep_take = SLEEP_INSTRUCTION_IN & (pwr_r == WDTPS_AWAKE);

  // clear and sleep both restart count and postscaler
  assign restart = WATCHDOG_CLEAR_INSTRUCTION_IN | sleep_take;

  // dedicated oscillator tick, never gated by sleep or run state
  // phase is never reset by clear or sleep, so a period varies by up to one tick
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      tick_div_r <= '0;
    end else if (tick_div_r == TICK_LAST) begin
      tick_div_r <= '0;
    end else begin
      tick_div_r <= tick_div_r + 1'b1;
    end
  end

  assign rc_tick = (tick_div_r == TICK_LAST);

  // base period counter
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      base_cnt_r <= '0;
    end else if (restart || !run) begin
      base_cnt_r <= '0;
    end else if (rc_tick) begin
      if (base_cnt_r == BASE_LAST) begin
        base_cnt_r <= '0;
      end else begin
        base_cnt_r <= base_cnt_r + 1'b1;
      end
    end
  end

  assign base_end = run & rc_tick & (base_cnt_r == BASE_LAST);

  // postscaler: count cleared, the fuse selection is left untouched
  // >= rather than == also recovers from a count beyond the limit
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      post_cnt_r <= '0;
    end else if (restart || !run) begin
      post_cnt_r <= '0;
    end else if (base_end) begin
      if (post_cnt_r >= post_limit) begin
        post_cnt_r <= '0;
      end else begin
        post_cnt_r <= post_cnt_r + 1'b1;
      end
    end
  end

  // a restart in the same cycle beats the time-out
  assign timeout = base_end & (post_cnt_r >= post_limit) & ~restart;

  // time-out resets when awake, wakes when asleep
  always_comb begin
    ev.reset = timeout & (pwr_r == WDTPS_AWAKE);
    ev.wake  = timeout & (pwr_r == WDTPS_ASLEEP);
  end

  // power state
  // other wake sources arrive on WAKE_EVENT_IN and leave the cause flags alone
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pwr_r <= WDTPS_AWAKE;
    end else begin
      case (pwr_r)
        WDTPS_AWAKE: begin
          if (sleep_take) begin
            pwr_r <= WDTPS_ASLEEP;
          end
        end
        WDTPS_ASLEEP: begin
          if (ev.wake || WAKE_EVENT_IN) begin
            pwr_r <= WDTPS_AWAKE;
          end
        end
        default: begin
          pwr_r <= WDTPS_AWAKE;
        end
      endcase
    end
  end

  // time-out and power-down flags of the reset-cause register
  // clear instruction leaves both flags alone; only reset sets pd again
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      to_flag_r <= CAUSE_TO_RESET;
      pd_flag_r <= CAUSE_PD_RESET;
    end else if (timeout) begin
      to_flag_r <= 1'b0;
    end else if (sleep_take) begin
      to_flag_r <= 1'b1;
      pd_flag_r <= 1'b0;
    end
  end

  // registered event pulses; reset request and wake are never both high
  // one cycle of latency buys a glitch-free pulse to the reset logic
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      ev_out_r <= '0;
    end else begin
      ev_out_r <= ev;
    end
  end

  assign WDT_RESET_OUT = ev_out_r.reset;
  assign WDT_WAKE_OUT  = ev_out_r.wake;
  assign ASLEEP_OUT    = (pwr_r == WDTPS_ASLEEP);

  // bus: one wait state, then the access completes
  assign bus_req   = AVS_READ_IN | AVS_WRITE_IN;
  assign bus_first = bus_req & ~ack_r;
  assign wr_take   = AVS_WRITE_IN & ack_r & AVS_BYTEENABLE_IN[0];

  // a fixed wait state lets read data come straight from a flop
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_first;
    end
  end

  assign AVS_WAITREQUEST_OUT = bus_req & ~ack_r;

  // write selects; address is held through the access, so decoding at completion is safe
  assign sel_soft    = (AVS_ADDRESS_IN == REG_SOFT_CTRL);
  assign sel_irq_en  = (AVS_ADDRESS_IN == REG_IRQ_EN);
  assign sel_irq_clr = (AVS_ADDRESS_IN == REG_IRQ_CLR);

  // software enable: one implemented bit
  // writes with byte lane 0 disabled are already dropped in wr_take
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      soft_en_r <= SOFT_EN_RESET;
    end else if (wr_take && sel_soft) begin
      soft_en_r <= AVS_WRITEDATA_IN[SOFT_EN_BIT];
    end
  end

  // interrupt enable
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_en_r <= IRQ_RESET;
    end else if (wr_take && sel_irq_en) begin
      irq_en_r <= AVS_WRITEDATA_IN[1:0];
    end
  end

  // sticky sources, in status-bit order
  always_comb begin
    irq_set              = 2'h0;
    irq_set[EV_RST_BIT]  = ev.reset;
    irq_set[EV_WAKE_BIT] = ev.wake;
  end

  // write-one-to-clear; a new event in the same cycle stays set
  always_comb begin
    irq_clr = 2'h0;
    if (wr_take && sel_irq_clr) begin
      irq_clr = AVS_WRITEDATA_IN[1:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_stat_r <= IRQ_RESET;
    end else begin
      irq_stat_r <= irq_set | (irq_stat_r & ~irq_clr);
    end
  end

  // level output, so a late handler still sees the event
  assign IRQ_OUT = |(irq_stat_r & irq_en_r);

  // read mux; unimplemented bits read zero
  always_comb begin
    rd_mux   = 32'h0000_0000;
    addr_hit = 1'b1;
    case (AVS_ADDRESS_IN)
      REG_SOFT_CTRL: begin
        rd_mux[SOFT_EN_BIT] = soft_en_r;
      end
      REG_FUSE: begin
        rd_mux[3:1]         = fuse_r.postscale_select;
        rd_mux[0]           = fuse_r.fuse_watchdog_enable;
      end
      REG_CAUSE: begin
        rd_mux[CAUSE_TO_BIT] = to_flag_r;
        rd_mux[CAUSE_PD_BIT] = pd_flag_r;
      end
      REG_IRQ_STAT: begin
        rd_mux[1:0] = irq_stat_r;
      end
      REG_IRQ_CLR: begin
        rd_mux = 32'h0000_0000;
      end
      REG_IRQ_EN: begin
        rd_mux[1:0] = irq_en_r;
      end
      REG_STATUS: begin
        rd_mux[ST_RUN_BIT]   = run;
        rd_mux[ST_SLEEP_BIT] = (pwr_r == WDTPS_ASLEEP);
      end
      REG_COUNT: begin
        rd_mux[BASE_W-1:0]                   = base_cnt_r;
        rd_mux[CNT_POST_LSB +: POST_W]       = post_cnt_r;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // read data and answer captured in the wait cycle, held until the next access
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= RESP_OKAY;
    end else if (bus_first) begin
      rdata_r <= AVS_READ_IN ? rd_mux : 32'h0000_0000;
      resp_r  <= addr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign AVS_READDATA_OUT = rdata_r;
  assign AVS_RESPONSE_OUT = resp_r;

endmodule // wdtps_top

// File: tb/wdtps_assertions.sv
// checker: port-level timing of the watchdog
// assumes binding into wdtps_top, single clock domain
`timescale 1ns/100ps
module wdtps_chk (
  // clock, reset, bus
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic AVS_WAITREQUEST_OUT,
  // cpu strobes and outputs
  input wire logic WATCHDOG_CLEAR_INSTRUCTION_IN,
  input wire logic SLEEP_INSTRUCTION_IN,
  input wire logic WAKE_EVENT_IN,
  input wire logic WDT_RESET_OUT,
  input wire logic WDT_WAKE_OUT,
  input wire logic ASLEEP_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_reset_pulse_one: assert property (WDT_RESET_OUT |=> !WDT_RESET_OUT)
    else $error("reset request longer than one cycle");
  a_wake_pulse_one: assert property (WDT_WAKE_OUT |=> !WDT_WAKE_OUT)
    else $error("wake pulse longer than one cycle");
  a_wake_ends_sleep: assert property (WDT_WAKE_OUT |-> !ASLEEP_OUT && $past(ASLEEP_OUT))
    else $error("wake pulse without leaving sleep");
  a_no_reset_asleep: assert property (WDT_RESET_OUT |-> !$past(ASLEEP_OUT))
    else $error("reset request raised while asleep");
  a_clear_blocks_to: assert property (
    WATCHDOG_CLEAR_INSTRUCTION_IN |=> !(WDT_RESET_OUT || WDT_WAKE_OUT) [*2])
    else $error("time-out right after clear");
  a_sleep_enters: assert property (
    SLEEP_INSTRUCTION_IN && !ASLEEP_OUT && !WAKE_EVENT_IN |=> ASLEEP_OUT)
    else $error("sleep instruction not taken");
  a_bus_one_wait: assert property (
    $rose(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("bus wait state count wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST_IN |=> !WDT_RESET_OUT && !WDT_WAKE_OUT && !ASLEEP_OUT)
    else $error("outputs active after reset");
endmodule // wdtps_chk

bind wdtps_top wdtps_chk u_chk (.CORE_CLK_IN, .SYS_RST_IN, .AVS_READ_IN, .AVS_WRITE_IN,
  .AVS_WAITREQUEST_OUT, .WATCHDOG_CLEAR_INSTRUCTION_IN, .SLEEP_INSTRUCTION_IN,
  .WAKE_EVENT_IN, .WDT_RESET_OUT, .WDT_WAKE_OUT, .ASLEEP_OUT);

// File: tb/tb_watchdog_timer_with_postscaler.sv
// testbench: watchdog with postscaler, self-checking
// assumes shortened tick and base counts to keep runs brief
`timescale 1ns/100ps
module tb_watchdog_timer_with_postscaler
  import wdtps_pkg::*;
;
  localparam int TK = 4;
  localparam int BT = 3;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, clr = 0, slp = 0, wk = 0;
  logic [4:0]  adr = '0;
  logic [31:0] wd = '0, rdat, q;
  logic [1:0]  resp, rs;
  logic        wreq, wrst, wwake, aslp, irq;
  wdtps_fuse_t fuse = 8'h01;
  int          err_total = 0, checks_done = 0, cyc = 0, rst_seen = 0, n;

  initial forever #25 clk = ~clk;

  wdtps_top #(.TICK_CYCLES(TK), .BASE_TICKS(BT)) dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq),
    .AVS_RESPONSE_OUT(resp), .FUSE_CFG_IN(fuse), .WATCHDOG_CLEAR_INSTRUCTION_IN(clr),
    .SLEEP_INSTRUCTION_IN(slp), .WAKE_EVENT_IN(wk), .WDT_RESET_OUT(wrst),
    .WDT_WAKE_OUT(wwake), .ASLEEP_OUT(aslp), .IRQ_OUT(irq));

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard, well above the longest scenario
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (wrst === 1'b1) rst_seen = rst_seen + 1;
    if (cyc == 12000) begin
      err_total++;
      end_of_test;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask

  // one avalon transfer, then one idle edge before the next
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // fuse only captured while reset is high
  task automatic reset_to(input logic [7:0] f);
    fuse <= f;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rst_seen = 0;
  endtask

  task automatic pulse(input logic s);
    if (s) slp <= 1'b1;
    else clr <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    clr <= 1'b0;
  endtask

  task automatic wait_hi(input logic w);
    n = 0;
    while ((w ? wwake : wrst) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_regs;
    reset_to(8'h01);
    bus(0, REG_SOFT_CTRL, 0); chk(q, 0);
    bus(0, REG_CAUSE, 0); chk(q, 32'h0000000C);
    bus(1, REG_SOFT_CTRL, 32'hFFFFFFFF);
    bus(0, REG_SOFT_CTRL, 0); chk(q, 32'h00000001);
    bus(0, 5'h02, 0); chk({q[29:0], rs}, 32'h00000002);
    bus(1, REG_FUSE, 0);
    bus(0, REG_FUSE, 0); chk(q, 32'h00000001);
    bus(1, REG_SOFT_CTRL, 0);
    bus(0, REG_STATUS, 0); chk(q, 32'h00000001);
    reset_to(8'h0E);
    bus(1, REG_SOFT_CTRL, 1);
    bus(0, REG_STATUS, 0); chk(q, 32'h00000001);
    bus(1, REG_SOFT_CTRL, 0);
    bus(0, REG_STATUS, 0); chk(q, 0);
    repeat (40) @(posedge clk);
    bus(0, REG_COUNT, 0); chk(q, 0);
    chk(rst_seen, 0);
  endtask

  task automatic t_post;
    int p;
    for (int s = 0; s < 8; s++) begin
      reset_to({4'h0, s[2:0], 1'b1});
      pulse(0);
      wait_hi(0);
      p = (128 >> s) * BT * TK;
      chk(n + 4 >= p && n <= p + 4, 1);
      bus(0, REG_CAUSE, 0); chk(q, 32'h00000004);
      bus(0, REG_IRQ_STAT, 0); chk(q, 32'h00000001);
      bus(0, REG_FUSE, 0); chk(q, {s[2:0], 1'b1});
    end
  endtask

  task automatic t_sleep;
    reset_to(8'h00);
    bus(1, REG_SOFT_CTRL, 1);
    bus(1, REG_IRQ_EN, 3);
    pulse(1);
    @(posedge clk);
    chk(aslp, 1);
    bus(0, REG_CAUSE, 0); chk(q, 32'h00000008);
    wait_hi(1);
    chk({aslp, irq}, 32'h00000001);
    chk(rst_seen, 0);
    bus(0, REG_CAUSE, 0); chk(q, 0);
    bus(1, REG_IRQ_EN, 1); chk(irq, 0);
    bus(1, REG_IRQ_EN, 2); chk(irq, 1);
    bus(1, REG_IRQ_CLR, 2); chk(irq, 0);
    bus(0, REG_IRQ_STAT, 0); chk(q, 0);
    // another wake source leaves sleep with no time-out pulse
    pulse(1);
    wk <= 1'b1;
    @(posedge clk);
    chk(aslp, 1);
    wk <= 1'b0;
    @(posedge clk);
    chk({aslp, wwake}, 0);
    bus(0, REG_CAUSE, 0); chk(q, 32'h00000008);
  endtask

  // clears closer than one period keep the count from expiring
  task automatic t_clear;
    reset_to(8'h0F);
    repeat (10) begin
      pulse(0);
      repeat (6) @(posedge clk);
    end
    chk(rst_seen, 0);
    wait_hi(0);
    chk(n <= 16, 1);
  endtask

  initial begin
    t_regs;
    t_post;
    t_sleep;
    t_clear;
    end_of_test;
  end
endmodule // tb_watchdog_timer_with_postscaler
